// ---- bench/dpt_switch_model.sv ----
// Power switch pair driven by one complementary output pair
`timescale 1ns/1ns
module dpt_switch_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic hi_drive,
    input wire logic hi_oe,
    input wire logic lo_drive,
    input wire logic lo_oe,
    output int overlap_count
);
    // Gate pull-downs keep an undriven switch off
    wire logic hi_gate = hi_oe & hi_drive;
    wire logic lo_gate = lo_oe & lo_drive;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            overlap_count <= 0;
        end else if (hi_gate && lo_gate) begin
            overlap_count <= overlap_count + 1;
        end
    end
endmodule

// ---- bench/test_dpt_timer.sv ----
// Self-checking bench for the dual complementary PWM timer
`timescale 1ns/1ns
module test_dpt_timer;
    import dpt_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pll_locked = 1'b0;
    logic [7:0] rdata;
    logic pll_enable, fast_clock_enable, irq;
    logic pwm_a_out, pwm_a_oe, pwm_a_n_out, pwm_a_n_oe;
    logic pwm_b_out, pwm_b_oe, pwm_b_n_out, pwm_b_n_oe;
    int err_total = 0;
    int compares = 0;
    int ovl_a, ovl_b, per, hi_t, hi_i;
    logic [7:0] rv;

    always #5 clock = ~clock;

    dpt_timer i_dpt_timer (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .pll_locked,
        .pll_enable, .fast_clock_enable, .pwm_a_out, .pwm_a_oe, .pwm_a_n_out, .pwm_a_n_oe,
        .pwm_b_out, .pwm_b_oe, .pwm_b_n_out, .pwm_b_n_oe, .irq);
    dpt_switch_model u_sw_a (.clock, .rstn, .hi_drive(pwm_a_out), .hi_oe(pwm_a_oe),
        .lo_drive(pwm_a_n_out), .lo_oe(pwm_a_n_oe), .overlap_count(ovl_a));
    dpt_switch_model u_sw_b (.clock, .rstn, .hi_drive(pwm_b_out), .hi_oe(pwm_b_oe),
        .lo_drive(pwm_b_n_out), .lo_oe(pwm_b_n_oe), .overlap_count(ovl_b));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // One period of channel A, rising edge to rising edge of the true pin
    task automatic measure;
        logic prev;
        int n;
        per = 0;
        hi_t = 0;
        hi_i = 0;
        n = 0;
        prev = 1'b1;
        while (!(prev === 1'b0 && pwm_a_out === 1'b1) && n < 5000) begin
            prev = pwm_a_out;
            cycles(1);
            n++;
        end
        do begin
            prev = pwm_a_out;
            if (pwm_a_out === 1'b1) hi_t++;
            if (pwm_a_n_out === 1'b1) hi_i++;
            cycles(1);
            per++;
        end while (!(prev === 1'b0 && pwm_a_out === 1'b1) && per < 5000);
        if (n >= 5000 || per >= 5000) begin
            err_total++;
            final_report();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int m;
        int h4;
        logic [7:0] v;
        logic t0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            rd_reg(4'(a), rv);
            chk(rv, 8'h00);
        end
        rd_reg(4'hF, rv);
        chk(rv, 8'h00);
        chk({irq, pwm_a_oe, pwm_a_n_oe, pwm_b_oe, pwm_b_n_oe}, 5'h00);
        $display("test reset done");

        wr_reg(DPT_OFF_PLL, 8'h04);
        cycles(1);
        chk(fast_clock_enable, 1'b0);
        wr_reg(DPT_OFF_PLL, 8'h02);
        cycles(20);
        pll_locked <= 1'b1;
        m = 0;
        rv = 8'h00;
        while (rv[DPT_PLL_LOCK] !== 1'b1 && m < 50) begin
            rd_reg(DPT_OFF_PLL, rv);
            m++;
        end
        chk(m < 50, 1'b1);
        wr_reg(DPT_OFF_PLL, 8'h06);
        cycles(1);
        chk({pll_enable, fast_clock_enable}, 2'h3);
        rd_reg(DPT_OFF_PLL, rv);
        chk(rv, 8'h07);
        $display("test pll done");

        wr_reg(DPT_OFF_TOP, 8'h09);
        wr_reg(DPT_OFF_CTRL, 8'h73);
        wr_reg(DPT_OFF_CMPA, 8'h04);
        wr_reg(DPT_OFF_CMPB, 8'h04);
        wr_reg(DPT_OFF_CLKSEL, 8'h01);
        wr_reg(DPT_OFF_CMPA, 8'h06);
        rd_reg(DPT_OFF_CMPA, rv);
        chk(rv, 8'h06);
        wr_reg(DPT_OFF_CMPA, 8'h04);
        rd_reg(DPT_OFF_CMPA, rv);
        chk(rv, 8'h04);
        cycles(30);
        measure();
        chk(16'(per), 16'd10);
        chk(hi_t < per - hi_t, 1'b1);
        chk(per - hi_t - hi_i >= 2, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rd_reg(DPT_OFF_COUNT, rv);
            chk(rv <= 8'h09, 1'b1);
        end
        wr_reg(DPT_OFF_CLKSEL, 8'h03);
        cycles(100);
        measure();
        chk(16'(per), 16'd40);
        chk(per - hi_t - hi_i >= 8, 1'b1);
        h4 = hi_t;
        wr_reg(DPT_OFF_CMPA, 8'h06);
        cycles(100);
        measure();
        chk(16'(hi_t - h4), 16'd8);
        wr_reg(DPT_OFF_CLKSEL, 8'h01);
        $display("test waveform done");

        // static levels at compare zero and top, every channel A mode, channel B in mode 11
        for (m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
                v = (k == 0) ? 8'h00 : 8'h09;
                wr_reg(DPT_OFF_CTRL, {m[1:0], 6'h33});
                wr_reg(DPT_OFF_CMPA, v);
                wr_reg(DPT_OFF_CMPB, v);
                cycles(40);
                t0 = pwm_a_out;
                cycles(7);
                chk(pwm_a_out, t0);
                chk({pwm_a_oe, pwm_a_n_oe}, {m != 0, m == 1});
                if (m != 0) chk(pwm_a_out, (m == 3) ? (k == 0) : (k == 1));
                if (m == 1) chk(pwm_a_n_out, k == 0);
                chk({pwm_b_out, pwm_b_n_oe, pwm_b_n_out}, {k == 0, 2'h0});
            end
        end
        wr_reg(DPT_OFF_CTRL, 8'h73);
        wr_reg(DPT_OFF_CMPA, 8'h04);
        cycles(40);
        $display("test static done");

        rd_reg(DPT_OFF_STATUS, rv);
        chk(rv & 8'h07, 8'h07);
        wr_reg(DPT_OFF_GIE, 8'h01);
        cycles(3);
        chk(irq, 1'b0);
        wr_reg(DPT_OFF_MASK, 8'h01);
        cycles(3);
        chk(irq, 1'b1);
        wr_reg(DPT_OFF_GIE, 8'h00);
        cycles(3);
        chk(irq, 1'b0);
        wr_reg(DPT_OFF_CLKSEL, 8'h00);
        cycles(5);
        rd_reg(DPT_OFF_COUNT, v);
        t0 = pwm_a_out;
        cycles(50);
        rd_reg(DPT_OFF_COUNT, rv);
        chk(rv, v);
        chk(pwm_a_out, t0);
        wr_reg(DPT_OFF_STATUS, 8'h07);
        rd_reg(DPT_OFF_STATUS, rv);
        chk(rv, 8'h00);
        wr_reg(DPT_OFF_GIE, 8'h01);
        cycles(3);
        chk(irq, 1'b0);
        chk(16'(ovl_a), 16'd0);
        chk(16'(ovl_b), 16'd0);
        $display("test interrupt done");
        final_report();
    end
endmodule

// ---- rtl/dpt_channel.sv ----
// One compare channel: buffered compare, output waveform and dead time
`timescale 1ns/1ns
module dpt_channel
    import dpt_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic tick,
    input wire logic pwm_enable,
    input wire logic [1:0] output_mode,
    input wire logic [7:0] counter_value,
    input wire logic at_top,
    input wire logic [7:0] top_value,
    input wire logic [7:0] cmp_wdata,
    input wire logic cmp_write,
    output logic [7:0] cmp_readback,
    output logic match,
    output logic true_drive,
    output logic true_oe,
    output logic inv_drive,
    output logic inv_oe
);
    import dpt_pkg::*;
    logic [7:0] active_reg;
    logic [7:0] buffer_reg;
    logic true_reg;
    logic inv_reg;
    logic true_dly_reg;
    logic inv_dly_reg;
    logic true_q_reg;
    logic inv_q_reg;
    logic true_next;
    logic inv_next;

    // RULE11: latest written value reads back
    assign cmp_readback = buffer_reg;
    assign match = tick && (counter_value == active_reg);
    // RULE8: waveform set and clear points
    always_comb begin
        true_next = true_reg;
        inv_next = inv_reg;
        if (tick) begin
            // RULE9: mode 11 sets after match
            if (output_mode == DPT_MODE_INV) begin
                if (counter_value == active_reg) true_next = 1'b1;
                else if (counter_value == DPT_RST_BYTE) true_next = 1'b0;
            end else begin
                if (counter_value == active_reg) true_next = 1'b0;
                else if (counter_value == DPT_CNT_ONE) true_next = 1'b1;
            end
            if (counter_value == active_reg) inv_next = 1'b1;
            else if (counter_value == DPT_RST_BYTE) inv_next = 1'b0;
            // RULE12: zero or top compare static
            if (active_reg == DPT_RST_BYTE) begin
                true_next = 1'b0;
                inv_next = 1'b1;
            end else if (active_reg == top_value) begin
                true_next = 1'b1;
                inv_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            active_reg <= DPT_RST_BYTE;
            buffer_reg <= DPT_RST_BYTE;
        end else begin
            // RULE10: buffered compare loads at top
            if (cmp_write) buffer_reg <= cmp_wdata;
            if (!pwm_enable) active_reg <= cmp_write ? cmp_wdata : buffer_reg;
            else if (at_top && tick) active_reg <= buffer_reg;
        end
    end

    // RULE4: rising edge delayed one prescaled plus one source cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            true_reg <= 1'b0;
            inv_reg <= 1'b0;
            true_dly_reg <= 1'b0;
            inv_dly_reg <= 1'b0;
            true_q_reg <= 1'b0;
            inv_q_reg <= 1'b0;
        end else begin
            true_reg <= true_next;
            inv_reg <= inv_next;
            // RULE19: hold when stopped
            if (tick) begin
                true_dly_reg <= true_reg;
                inv_dly_reg <= inv_reg;
            end
            // RULE3: dead time one prescaled cycle
            true_q_reg <= true_reg & true_dly_reg;
            inv_q_reg <= inv_reg & inv_dly_reg;
        end
    end

    // RULE7: mode field connects outputs
    // RULE2: pair never high together
    assign true_oe = pwm_enable && (output_mode != DPT_MODE_OFF);
    assign inv_oe = pwm_enable && (output_mode == DPT_MODE_PAIR);
    assign true_drive = true_oe && (output_mode == DPT_MODE_INV ? inv_q_reg : true_q_reg);
    assign inv_drive = inv_oe && inv_q_reg && !true_q_reg;
endmodule

// ---- rtl/dpt_pkg.sv ----
// Package: register map, field layout and constants of the dual PWM timer
package dpt_pkg;
    localparam int DPT_AW = 4;
    localparam int DPT_DW = 8;
    // Register offsets
    localparam logic [3:0] DPT_OFF_CTRL = 4'h0;
    localparam logic [3:0] DPT_OFF_CLKSEL = 4'h1;
    localparam logic [3:0] DPT_OFF_COUNT = 4'h2;
    localparam logic [3:0] DPT_OFF_CMPA = 4'h3;
    localparam logic [3:0] DPT_OFF_CMPB = 4'h4;
    localparam logic [3:0] DPT_OFF_TOP = 4'h5;
    localparam logic [3:0] DPT_OFF_PLL = 4'h6;
    localparam logic [3:0] DPT_OFF_STATUS = 4'h7;
    localparam logic [3:0] DPT_OFF_MASK = 4'h8;
    localparam logic [3:0] DPT_OFF_GIE = 4'h9;
    // Control fields: [7:6] mode A, [5:4] mode B, [1] pwm A, [0] pwm B
    localparam int DPT_CTRL_MODE_A = 6;
    localparam int DPT_CTRL_MODE_B = 4;
    localparam int DPT_CTRL_PWM_A = 1;
    localparam int DPT_CTRL_PWM_B = 0;
    // PLL fields
    localparam int DPT_PLL_LOCK = 0;
    localparam int DPT_PLL_EN = 1;
    localparam int DPT_PLL_FAST = 2;
    // Status / mask bits
    localparam int DPT_ST_OVF = 0;
    localparam int DPT_ST_CMPA = 1;
    localparam int DPT_ST_CMPB = 2;
    localparam int DPT_NFLAG = 3;
    // Reset values
    localparam logic [7:0] DPT_RST_BYTE = 8'h00;
    localparam logic [7:0] DPT_CNT_ONE = 8'h01;
    localparam logic [3:0] DPT_CS_STOP = 4'h0;
    localparam int DPT_PRE_W = 14;
    // Fast clock rate, informational only: one clock domain here
    localparam int DPT_FAST_MHZ = 64;
    localparam int DPT_SYS_MHZ = 100;
    // Output mode encodings
    localparam logic [1:0] DPT_MODE_OFF = 2'h0;
    localparam logic [1:0] DPT_MODE_PAIR = 2'h1;
    localparam logic [1:0] DPT_MODE_TRUE = 2'h2;
    localparam logic [1:0] DPT_MODE_INV = 2'h3;
endpackage

// ---- rtl/dpt_prescaler.sv ----
// Prescaler: source clock divided by two to the power of select minus one
`timescale 1ns/1ns
module dpt_prescaler
    import dpt_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] clock_select_field,
    output logic tick
);
    import dpt_pkg::*;
    logic [DPT_PRE_W-1:0] div_reg;
    logic [DPT_PRE_W-1:0] div_next;
    logic [DPT_PRE_W-1:0] div_mask;
    logic run;

    // RULE18: divide by power of two
    assign run = clock_select_field != DPT_CS_STOP;
    assign div_mask = run ? DPT_PRE_W'((15'h0001 << (clock_select_field - 4'h1)) - 15'h0001)
                          : '0;
    assign div_next = ((div_reg & div_mask) == div_mask) ? '0 : div_reg + 1'b1;
    assign tick = run && ((div_reg & div_mask) == div_mask);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_reg <= '0;
        end else if (run) begin
            div_reg <= div_next;
        end
    end
endmodule

// ---- rtl/dpt_timer.sv ----
// Top: dual complementary PWM timer with register port and interrupt
//
// Contract
// RULE1: software locks PLL before fast clock
// RULE2: two channels, pair never both high
// RULE3: dead time one prescaled cycle
// RULE4: rising edges delayed, falling one cycle
// RULE5: counter runs zero to top, repeats (here only with a PWM enable set, otherwise it rolls over at full count)
// RULE6: top match sets overflow flag
// RULE7: mode 00 off, 10 true only
// RULE8: mode 01 drives true and inverted
// RULE9: mode 11 inverted waveform on true
// RULE10: compare writes buffered until top
// RULE11: compare reads return buffered value
// RULE12: compare zero or top holds static
// RULE13: flags interrupt with enable and global
// RULE14: period is top plus one
// RULE15: pwm enable selects mode, wraps after top
// RULE16: fast enable selects timer source (here one source clock, fast enable only flagged outward)
// RULE17: fast enable only with PLL enabled
// RULE18: clock select divides, zero stops
// RULE19: stopped timer holds all state
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
module dpt_timer
    import dpt_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [dpt_pkg::DPT_AW-1:0] addr,
    input wire logic [dpt_pkg::DPT_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [dpt_pkg::DPT_DW-1:0] rdata,
    input wire logic pll_locked,
    output logic pll_enable,
    output logic fast_clock_enable,
    output logic pwm_a_out,
    output logic pwm_a_oe,
    output logic pwm_a_n_out,
    output logic pwm_a_n_oe,
    output logic pwm_b_out,
    output logic pwm_b_oe,
    output logic pwm_b_n_out,
    output logic pwm_b_n_oe,
    output logic irq
);
    import dpt_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] timer_control_a;
    logic [3:0] clock_select_field;
    logic [7:0] counter_value;
    logic [7:0] top_value_reg;
    logic pll_en_reg;
    logic fast_en_reg;
    logic [DPT_NFLAG-1:0] status_reg;
    logic [DPT_NFLAG-1:0] status_next;
    logic [DPT_NFLAG-1:0] mask_reg;
    logic gie_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_reg;
    logic [7:0] counter_next;
    logic [7:0] compare_a_reg;
    logic [7:0] compare_b_reg;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic wr_ctrl, wr_cs, wr_cnt, wr_cmpa, wr_cmpb, wr_top, wr_pll, wr_st, wr_mask, wr_gie;
    assign wr_ctrl = wr && (addr == DPT_OFF_CTRL);
    assign wr_cs = wr && (addr == DPT_OFF_CLKSEL);
    assign wr_cnt = wr && (addr == DPT_OFF_COUNT);
    assign wr_cmpa = wr && (addr == DPT_OFF_CMPA);
    assign wr_cmpb = wr && (addr == DPT_OFF_CMPB);
    assign wr_top = wr && (addr == DPT_OFF_TOP);
    assign wr_pll = wr && (addr == DPT_OFF_PLL);
    assign wr_st = wr && (addr == DPT_OFF_STATUS);
    assign wr_mask = wr && (addr == DPT_OFF_MASK);
    assign wr_gie = wr && (addr == DPT_OFF_GIE);

    logic pwm_enable_a;
    logic pwm_enable_b;
    logic any_pwm;
    assign pwm_enable_a = timer_control_a[DPT_CTRL_PWM_A];
    assign pwm_enable_b = timer_control_a[DPT_CTRL_PWM_B];
    assign any_pwm = pwm_enable_a || pwm_enable_b;

    // ----------------------------------------
    // Prescaler and counter
    // ----------------------------------------
    logic tick;
    logic at_top;
    logic top_match;
    // RULE16: single source clock here, fast mode only flagged outward
    dpt_prescaler u_pre (
        .clock(clock),
        .rstn(rstn),
        .clock_select_field(clock_select_field),
        .tick(tick)
    );

    assign at_top = counter_value == top_value_reg;
    assign top_match = tick && at_top;

    // RULE5: count up, wrap after top while a PWM enable is set, else roll over at full count
    // RULE15: wrap in cycle after top match
    // RULE14: period top plus one ticks
    always_comb begin
        counter_next = counter_value;
        if (wr_cnt) counter_next = wdata;
        else if (tick) counter_next = (at_top && any_pwm) ? DPT_RST_BYTE
                                                          : counter_value + 8'h01;
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    logic match_a, match_b;
    logic a_d, a_e, an_d, an_e, b_d, b_e, bn_d, bn_e;
    dpt_channel u_ch_a (
        .clock(clock),
        .rstn(rstn),
        .tick(tick),
        .pwm_enable(pwm_enable_a),
        .output_mode(timer_control_a[DPT_CTRL_MODE_A +: 2]),
        .counter_value(counter_value),
        .at_top(at_top),
        .top_value(top_value_reg),
        .cmp_wdata(wdata),
        .cmp_write(wr_cmpa),
        .cmp_readback(compare_a_reg),
        .match(match_a),
        .true_drive(a_d),
        .true_oe(a_e),
        .inv_drive(an_d),
        .inv_oe(an_e)
    );
    dpt_channel u_ch_b (
        .clock(clock),
        .rstn(rstn),
        .tick(tick),
        .pwm_enable(pwm_enable_b),
        .output_mode(timer_control_a[DPT_CTRL_MODE_B +: 2]),
        .counter_value(counter_value),
        .at_top(at_top),
        .top_value(top_value_reg),
        .cmp_wdata(wdata),
        .cmp_write(wr_cmpb),
        .cmp_readback(compare_b_reg),
        .match(match_b),
        .true_drive(b_d),
        .true_oe(b_e),
        .inv_drive(bn_d),
        .inv_oe(bn_e)
    );

    // ----------------------------------------
    // Flags, interrupt, read mux
    // ----------------------------------------
    logic [DPT_NFLAG-1:0] events;
    // RULE6: overflow on top match
    assign events = {match_b, match_a, top_match};
    // Set wins over write-one clear
    assign status_next = (status_reg & ~(wr_st ? wdata[DPT_NFLAG-1:0] : '0)) | events;

    always_comb begin
        case (addr)
            DPT_OFF_CTRL: rdata_next = timer_control_a;
            DPT_OFF_CLKSEL: rdata_next = {4'h0, clock_select_field};
            DPT_OFF_COUNT: rdata_next = counter_value;
            DPT_OFF_CMPA: rdata_next = compare_a_reg;
            DPT_OFF_CMPB: rdata_next = compare_b_reg;
            DPT_OFF_TOP: rdata_next = top_value_reg;
            DPT_OFF_PLL: rdata_next = {5'h00, fast_en_reg, pll_en_reg, pll_locked};
            DPT_OFF_STATUS: rdata_next = {5'h00, status_reg};
            DPT_OFF_MASK: rdata_next = {5'h00, mask_reg};
            DPT_OFF_GIE: rdata_next = {7'h00, gie_reg};
            default: rdata_next = DPT_RST_BYTE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer_control_a <= DPT_RST_BYTE;
            clock_select_field <= DPT_CS_STOP;
            counter_value <= DPT_RST_BYTE;
            top_value_reg <= DPT_RST_BYTE;
            pll_en_reg <= 1'b0;
            fast_en_reg <= 1'b0;
            status_reg <= '0;
            mask_reg <= '0;
            gie_reg <= 1'b0;
            rdata_reg <= DPT_RST_BYTE;
            irq_reg <= 1'b0;
        end else begin
            if (wr_ctrl) timer_control_a <= wdata;
            if (wr_cs) clock_select_field <= wdata[3:0];
            if (wr_top) top_value_reg <= wdata;
            if (wr_mask) mask_reg <= wdata[DPT_NFLAG-1:0];
            if (wr_gie) gie_reg <= wdata[0];
            // RULE17: fast enable needs PLL enable
            if (wr_pll) begin
                pll_en_reg <= wdata[DPT_PLL_EN];
                fast_en_reg <= wdata[DPT_PLL_FAST] & wdata[DPT_PLL_EN];
            end
            counter_value <= counter_next;
            status_reg <= status_next;
            rdata_reg <= rd ? rdata_next : DPT_RST_BYTE;
            // RULE13: flag, own enable and global enable
            irq_reg <= gie_reg && |(status_reg & mask_reg);
        end
    end

    // Output pins registered once more so every top output is a flop
    logic [7:0] pin_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) pin_reg <= DPT_RST_BYTE;
        else pin_reg <= {a_d, a_e, an_d, an_e, b_d, b_e, bn_d, bn_e};
    end

    assign {pwm_a_out, pwm_a_oe, pwm_a_n_out, pwm_a_n_oe} = pin_reg[7:4];
    assign {pwm_b_out, pwm_b_oe, pwm_b_n_out, pwm_b_n_oe} = pin_reg[3:0];
    assign pll_enable = pll_en_reg;
    assign fast_clock_enable = fast_en_reg;
    assign rdata = rdata_reg;
    assign irq = irq_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_pair_a;
        @(posedge clock) disable iff (!rstn) !(pwm_a_out && pwm_a_n_out);
    endproperty
    a_pair_a: assert property (p_pair_a) else $error("pair A both high"); // RULE2

    property p_pair_b;
        @(posedge clock) disable iff (!rstn) !(pwm_b_out && pwm_b_n_out);
    endproperty
    a_pair_b: assert property (p_pair_b) else $error("pair B both high"); // RULE2

    property p_wrap;
        @(posedge clock) disable iff (!rstn)
            (tick && at_top && any_pwm && !wr_cnt) |=> counter_value == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // RULE15

    property p_count;
        @(posedge clock) disable iff (!rstn)
            (tick && !at_top && !wr_cnt) |=> counter_value == $past(counter_value) + 8'h01;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step"); // RULE5

    property p_ovf;
        @(posedge clock) disable iff (!rstn) top_match |=> status_reg[DPT_ST_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missing"); // RULE6

    property p_stop;
        @(posedge clock) disable iff (!rstn)
            (clock_select_field == 4'h0 && !wr_cnt) |=> $stable(counter_value);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped counter moved"); // RULE19

    property p_fast;
        @(posedge clock) disable iff (!rstn) fast_en_reg |-> pll_en_reg;
    endproperty
    a_fast: assert property (p_fast) else $error("fast clock without PLL"); // RULE17

    property p_irq;
        @(posedge clock) disable iff (!rstn)
            (gie_reg && |(status_reg & mask_reg)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // RULE13

    property p_readback;
        @(posedge clock) disable iff (!rstn)
            (wr_cmpa ##1 !wr ##1 (rd && addr == DPT_OFF_CMPA && !wr))
                |=> rdata == $past(wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("compare readback wrong"); // RULE11

    property p_stop_pins;
        @(posedge clock) disable iff (!rstn)
            (clock_select_field == DPT_CS_STOP && !wr_ctrl) [*4] |=> $stable(pwm_a_out);
    endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("stopped output moved"); // RULE19

    property p_mode_off;
        @(posedge clock) disable iff (!rstn)
            (timer_control_a[DPT_CTRL_MODE_A +: 2] == DPT_MODE_OFF)
                |=> (!pwm_a_oe && !pwm_a_n_oe);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("pins driven in mode off"); // RULE7

    property p_inv_pin;
        @(posedge clock) disable iff (!rstn)
            (timer_control_a[DPT_CTRL_MODE_B +: 2] == DPT_MODE_INV) |=> !pwm_b_n_oe;
    endproperty
    a_inv_pin: assert property (p_inv_pin) else $error("inverted pin driven in mode 11"); // RULE9

    property p_irq_off;
        @(posedge clock) disable iff (!rstn) !gie_reg |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without global enable"); // RULE13
endmodule
